//--- core/ftu_core.v
// Floating-point transfer, copy, multiply, negate and round-to-long unit.
`timescale 1ns/10ps
`default_nettype none
`include "ftu_defs.vh"
module ftu_core (
    input wire mclk_i,              // core clock
    input wire rstn_i,              // synchronous reset, active low
    input wire issue_i,             // instruction valid this cycle
    input wire [31:0] instr_i,      // instruction word
    input wire [63:0] base_val_i,   // base integer register value
    input wire [63:0] int_val_i,    // integer target register value
    input wire [63:0] mem_data_i,   // aligned doubleword from memory
    input wire mem_valid_i,         // memory data valid
    input wire [3:0] reg_addr_i,    // register port address
    input wire [31:0] reg_wdata_i,  // register write data
    input wire reg_wr_i,            // register write strobe
    input wire reg_rd_i,            // register read strobe
    output reg [31:0] reg_rdata_o,  // register read data
    output reg busy_o,              // load outstanding, issue refused
    output reg mem_req_o,           // memory read request pulse
    output reg [63:0] mem_addr_o,   // memory address
    output reg mem_word_o,          // request is a word load
    output reg int_we_o,            // integer register write pulse
    output reg [4:0] int_dest_o,    // integer destination number
    output reg [63:0] int_wdata_o,  // integer write data
    output reg addr_err_o,          // address error pulse
    output reg unimpl_o,            // unimplemented operation pulse
    output reg fpe_o                // invalid-operation trap pulse
);

localparam ST_IDLE = 1'b0;
localparam ST_WAIT = 1'b1;

////////////////////////////////////////////////////////////////////////////////

function [4:0] idx32;
    input [4:0] n;
    input w;
    idx32 = w ? n : {n[4:1], 1'b0};
endfunction

function [31:0] rd32;
    input [63:0] e;
    input [4:0] n;
    input w;
    rd32 = (w | ~n[0]) ? e[31:0] : e[63:32];
endfunction

// Subnormal operands are taken as zero; the unit has no denormal path.
function [66:0] unpk;
    input [63:0] v;
    input d;
    reg [10:0] e;
    reg [52:0] m;
    reg ez;
    reg eo;
    reg fz;
    begin
        e = d ? v[62:52] : {3'b000, v[30:23]};
        m = d ? {1'b1, v[51:0]} : {1'b1, v[22:0], 29'h0};
        ez = d ? (v[62:52] == 11'h000) : (v[30:23] == 8'h00);
        eo = d ? (v[62:52] == 11'h7FF) : (v[30:23] == 8'hFF);
        fz = d ? (v[51:0] == 52'h0) : (v[22:0] == 23'h0);
        unpk = {eo & ~fz, eo & fz, ez, e, m};
    end
endfunction

function rinc;
    input [1:0] md;
    input s;
    input l;
    input g;
    input t;
    case (md)
        2'b00: rinc = g & (t | l);
        2'b01: rinc = 1'b0;
        2'b10: rinc = ~s & (g | t);
        default: rinc = s & (g | t);
    endcase
endfunction

function [63:0] pk;
    input d;
    input s;
    input [10:0] e;
    input [51:0] f;
    pk = d ? {s, e, f} : {32'h0, s, e[7:0], f[22:0]};
endfunction

////////////////////////////////////////////////////////////////////////////////

reg [31:0] ctrl_reg;
reg [5:0] flag_reg;
reg state_reg;
reg [4:0] ld_ix_reg;
reg ld_word_reg;
reg ld_sel_reg;
reg wb_v_reg;
reg [4:0] wb_ix_reg;
reg [63:0] wb_d_reg;
reg wb_lo_reg;
reg wb_hi_reg;
reg [63:0] fgr_mem [0:31];

wire wid = ctrl_reg[`FTU_CTRL_WIDTH];
wire m64 = ctrl_reg[`FTU_CTRL_MODE64];
wire [1:0] rmode = ctrl_reg[`FTU_CTRL_RM];
wire inv_en = ctrl_reg[`FTU_CTRL_INV_EN];
wire [5:0] op = instr_i[`FTU_F_OP];
wire [4:0] fmt = instr_i[`FTU_F_FMT];
wire [4:0] ft = instr_i[`FTU_F_FT];
wire [4:0] fs = instr_i[`FTU_F_FS];
wire [4:0] fd = instr_i[`FTU_F_FD];
wire [5:0] fn = instr_i[`FTU_F_FN];
wire take = issue_i & ~busy_o;
wire is_ldd = take & (op == `FTU_OP_LOAD_DOUBLE);
wire is_ldw = take & (op == `FTU_OP_LOAD_WORD);
wire is_cop = take & (op == `FTU_OP_COP);
wire is_mf = is_cop & (fmt == `FTU_RS_MOVE_FROM);
wire is_mt = is_cop & (fmt == `FTU_RS_MOVE_TO);
wire f_mul = (fn == `FTU_FN_MUL);
wire f_cpy = (fn == `FTU_FN_COPY);
wire f_neg = (fn == `FTU_FN_NEG);
wire f_rnd = (fn == `FTU_FN_ROUND_L);
wire is_ar = is_cop & fmt[4] & (f_mul | f_cpy | f_neg | f_rnd);
wire dbl = (fmt == `FTU_FMT_D);
wire fmt_ok = dbl | (fmt == `FTU_FMT_S);

wire [63:0] sx_off = {{48{instr_i[15]}}, instr_i[`FTU_F_IMM]};
wire [63:0] ea_raw = base_val_i + sx_off;
wire [63:0] ea = m64 ? ea_raw : {{32{ea_raw[31]}}, ea_raw[31:0]};
wire mis_d = (ea[2:0] != 3'b000);
wire mis_w = (ea[1:0] != 2'b00);

// Narrow mode reads take the even entry and the half chosen by bit 0.
wire [63:0] a_ent = fgr_mem[idx32(fs, wid)];
wire [63:0] b_ent = fgr_mem[idx32(ft, wid)];
wire [31:0] fs32 = rd32(a_ent, fs, wid);
wire [63:0] opa = dbl ? fgr_mem[fs] : {32'h0, rd32(a_ent, fs, wid)};
wire [63:0] opb = dbl ? fgr_mem[ft] : {32'h0, rd32(b_ent, ft, wid)};
wire sa = dbl ? opa[63] : opa[31];
wire sb = dbl ? opb[63] : opb[31];

////////////////////////////////////////////////////////////////////////////////

reg [66:0] ua;
reg [66:0] ub;
reg [105:0] prod;
reg [105:0] nrm;
reg [12:0] bias;
reg [12:0] ex;
reg [12:0] exf;
reg [52:0] kept;
reg [53:0] rm;
reg g_b;
reg t_b;
reg ms;
reg carry;
reg to_inf;
reg [63:0] mul_res;
reg mul_inv;
reg mul_inx;
reg mul_ovf;
reg mul_unf;

always @* begin
    ua = unpk(opa, dbl);
    ub = unpk(opb, dbl);
    ms = sa ^ sb;
    bias = dbl ? `FTU_BIAS_D : `FTU_BIAS_S;
    prod = ua[52:0] * ub[52:0];
    nrm = prod[105] ? prod : {prod[104:0], 1'b0};
    ex = {2'b00, ua[63:53]} + {2'b00, ub[63:53]} - bias + {12'h000, prod[105]};
    kept = dbl ? nrm[105:53] : {29'h0, nrm[105:82]};
    g_b = dbl ? nrm[52] : nrm[81];
    t_b = dbl ? (nrm[51:0] != 52'h0) : (nrm[80:0] != 81'h0);
    rm = {1'b0, kept} + {53'h0, rinc(rmode, ms, kept[0], g_b, t_b)};
    carry = dbl ? rm[53] : rm[24];
    exf = ex + {12'h000, carry};
    to_inf = (rmode == 2'b00) | ((rmode == 2'b10) & ~ms) | ((rmode == 2'b11) & ms);
    mul_inv = 1'b0;
    mul_inx = g_b | t_b;
    mul_ovf = 1'b0;
    mul_unf = 1'b0;
    mul_res = pk(dbl, ms, exf[10:0], dbl ? rm[51:0] : {29'h0, rm[22:0]});
    if (ua[66] | ub[66] | ((ua[65] | ub[65]) & (ua[64] | ub[64]))) begin
        mul_inv = 1'b1;
        mul_inx = 1'b0;
        mul_res = dbl ? `FTU_NAN_D : `FTU_NAN_S;
    end else if (ua[65] | ub[65]) begin
        mul_inx = 1'b0;
        mul_res = pk(dbl, ms, `FTU_EXP_INF, 52'h0);
    end else if (ua[64] | ub[64]) begin
        mul_inx = 1'b0;
        mul_res = pk(dbl, ms, 11'h000, 52'h0);
    end else if ($signed(exf) > $signed(dbl ? `FTU_EMAX_D : `FTU_EMAX_S)) begin
        mul_ovf = 1'b1;
        mul_inx = 1'b1;
        mul_res = to_inf ? pk(dbl, ms, `FTU_EXP_INF, 52'h0) :
                  pk(dbl, ms, `FTU_EXP_MAX, `FTU_FRAC_ONES);
    end else if ($signed(exf) < $signed(13'h0001)) begin
        // Tiny results flush to signed zero to keep the datapath small.
        mul_unf = 1'b1;
        mul_inx = 1'b1;
        mul_res = pk(dbl, ms, 11'h000, 52'h0);
    end
end

////////////////////////////////////////////////////////////////////////////////

reg [12:0] er;
reg [12:0] sh;
reg [127:0] rz;
reg [64:0] mag;
reg big;
reg r_inx;
reg rnd_inv;
reg [63:0] rnd_res;

always @* begin
    er = {2'b00, ua[63:53]} - bias;
    big = ($signed(er) >= $signed(13'h003F));
    sh = 13'h0034 - er;
    rz = 128'h0;
    if (big) begin
        rz = 128'h0;
    end else if ($signed(er) >= $signed(13'h0034)) begin
        rz = {11'h000, ua[52:0], 64'h0} << (er - 13'h0034);
    end else if (sh <= 13'h007F) begin
        rz = {11'h000, ua[52:0], 64'h0} >> sh[6:0];
    end
    if (ua[64]) begin
        rz = 128'h0;
    end
    mag = {1'b0, rz[127:64]} + {64'h0, rinc(2'b00, sa, rz[64], rz[63], rz[62:0] != 63'h0)};
    r_inx = rz[63] | (rz[62:0] != 63'h0);
    rnd_inv = ua[66] | ua[65] |
              (big & ~(sa & (er == 13'h003F) & (ua[51:0] == 52'h0))) |
              (~big & ~sa & mag[63]);
    if (rnd_inv) begin
        rnd_res = `FTU_LONG_MAX;
    end else if (big) begin
        rnd_res = `FTU_LONG_MIN;
    end else begin
        rnd_res = sa ? (64'h0 - mag[63:0]) : mag[63:0];
    end
end

////////////////////////////////////////////////////////////////////////////////

reg f_en;
reg [4:0] f_ix;
reg [63:0] f_d;
reg h_en;
reg [4:0] h_n;
reg [31:0] h_v;
reg [5:0] fl_set;
reg trap;
reg bad_fmt;
reg [63:0] ar_res;

always @* begin
    f_en = 1'b0;
    f_ix = 5'h00;
    f_d = 64'h0;
    h_en = 1'b0;
    h_n = 5'h00;
    h_v = 32'h0;
    fl_set = 6'h00;
    trap = 1'b0;
    bad_fmt = is_ar & ~fmt_ok;
    ar_res = opa;
    if (state_reg == ST_WAIT && mem_valid_i) begin
        if (ld_word_reg) begin
            h_en = 1'b1;
            h_n = ld_ix_reg;
            h_v = ld_sel_reg ? mem_data_i[63:32] : mem_data_i[31:0];
        end else begin
            f_en = 1'b1;
            f_ix = ld_ix_reg;
            f_d = mem_data_i;
        end
    end
    if (is_mt) begin
        h_en = 1'b1;
        h_n = fs;
        h_v = int_val_i[31:0];
    end
    if (is_ldd & mis_d) begin
        fl_set[`FTU_FL_ADDR] = 1'b1;
    end
    if (is_ldw & mis_w) begin
        fl_set[`FTU_FL_ADDR] = 1'b1;
    end
    if (bad_fmt) begin
        fl_set[`FTU_FL_UNIMP] = 1'b1;
    end else if (is_ar) begin
        if (f_cpy) begin
            ar_res = opa;
        end else if (f_neg) begin
            ar_res = dbl ? {~opa[63], opa[62:0]} : {32'h0, ~opa[31], opa[30:0]};
            fl_set[`FTU_FL_INV] = ua[66];
        end else if (f_mul) begin
            ar_res = mul_res;
            fl_set[`FTU_FL_INV] = mul_inv;
            fl_set[`FTU_FL_INX] = mul_inx;
            fl_set[`FTU_FL_OVF] = mul_ovf;
            fl_set[`FTU_FL_UNF] = mul_unf;
        end else begin
            ar_res = rnd_res;
            fl_set[`FTU_FL_INV] = rnd_inv;
            fl_set[`FTU_FL_INX] = r_inx & ~rnd_inv;
        end
        trap = fl_set[`FTU_FL_INV] & inv_en;
        if (!trap) begin
            if (dbl | f_rnd) begin
                f_en = 1'b1;
                f_ix = fd;
                f_d = ar_res;
            end else begin
                h_en = 1'b1;
                h_n = fd;
                h_v = ar_res[31:0];
            end
        end
    end
end

////////////////////////////////////////////////////////////////////////////////

// Every register file write lands one cycle after its cause, so a reader in
// the next cycle sees the old contents; nothing is bypassed around it.
always @(posedge mclk_i) begin
    if (wb_v_reg) begin
        if (wb_lo_reg) begin
            fgr_mem[wb_ix_reg][31:0] <= wb_d_reg[31:0];
        end
        if (wb_hi_reg) begin
            fgr_mem[wb_ix_reg][63:32] <= wb_d_reg[63:32];
        end
    end
end

always @(posedge mclk_i) begin
    if (!rstn_i) begin
        wb_v_reg <= 1'b0;
        wb_ix_reg <= 5'h00;
        wb_d_reg <= 64'h0;
        wb_lo_reg <= 1'b0;
        wb_hi_reg <= 1'b0;
    end else begin
        wb_v_reg <= f_en | h_en;
        wb_ix_reg <= f_en ? f_ix : idx32(h_n, wid);
        if (f_en) begin
            wb_d_reg <= f_d;
            wb_lo_reg <= 1'b1;
            wb_hi_reg <= 1'b1;
        end else if (wid) begin
            wb_d_reg <= {32'h0, h_v};
            wb_lo_reg <= 1'b1;
            wb_hi_reg <= 1'b1;
        end else begin
            wb_d_reg <= {h_v, h_v};
            wb_lo_reg <= ~h_n[0];
            wb_hi_reg <= h_n[0];
        end
    end
end

always @(posedge mclk_i) begin
    if (!rstn_i) begin
        state_reg <= ST_IDLE;
        busy_o <= 1'b0;
        mem_req_o <= 1'b0;
        mem_addr_o <= 64'h0;
        mem_word_o <= 1'b0;
        ld_ix_reg <= 5'h00;
        ld_word_reg <= 1'b0;
        ld_sel_reg <= 1'b0;
        addr_err_o <= 1'b0;
        unimpl_o <= 1'b0;
        fpe_o <= 1'b0;
        int_we_o <= 1'b0;
        int_dest_o <= 5'h00;
        int_wdata_o <= 64'h0;
    end else begin
        mem_req_o <= 1'b0;
        addr_err_o <= (is_ldd & mis_d) | (is_ldw & mis_w);
        unimpl_o <= bad_fmt;
        fpe_o <= trap;
        int_we_o <= is_mf;
        if (is_mf) begin
            int_dest_o <= ft;
            int_wdata_o <= m64 ? {{32{fs32[31]}}, fs32} : {32'h0, fs32};
        end
        case (state_reg)
            ST_IDLE: begin
                if ((is_ldd & ~mis_d) | (is_ldw & ~mis_w)) begin
                    state_reg <= ST_WAIT;
                    busy_o <= 1'b1;
                    mem_req_o <= 1'b1;
                    mem_word_o <= is_ldw;
                    mem_addr_o <= {ea[63:3], ea[2] ^ (is_ldw &
                                   ctrl_reg[`FTU_CTRL_REV_END]), 2'b00};
                    ld_ix_reg <= ft;
                    ld_word_reg <= is_ldw;
                    ld_sel_reg <= ea[2] ^ ctrl_reg[`FTU_CTRL_BIG_END];
                end
            end
            ST_WAIT: begin
                if (mem_valid_i) begin
                    state_reg <= ST_IDLE;
                    busy_o <= 1'b0;
                end
            end
            default: begin
                state_reg <= ST_IDLE;
                busy_o <= 1'b0;
            end
        endcase
    end
end

// Flag clears are write-one-to-clear; a set in the same cycle wins.
always @(posedge mclk_i) begin
    if (!rstn_i) begin
        ctrl_reg <= `FTU_CTRL_RESET;
        flag_reg <= `FTU_FLAGS_RESET;
        reg_rdata_o <= 32'h0;
    end else begin
        if (reg_wr_i && reg_addr_i == `FTU_ADDR_CTRL) begin
            ctrl_reg <= reg_wdata_i & `FTU_CTRL_MASK;
        end
        if (reg_wr_i && reg_addr_i == `FTU_ADDR_FLAGS) begin
            flag_reg <= (flag_reg & ~reg_wdata_i[5:0]) | fl_set;
        end else begin
            flag_reg <= flag_reg | fl_set;
        end
        if (reg_rd_i && reg_addr_i == `FTU_ADDR_CTRL) begin
            reg_rdata_o <= ctrl_reg;
        end else if (reg_rd_i && reg_addr_i == `FTU_ADDR_FLAGS) begin
            reg_rdata_o <= {26'h0, flag_reg};
        end else begin
            reg_rdata_o <= 32'h0;
        end
    end
end

endmodule
`default_nettype wire

//--- core/ftu_defs.vh
// Constants for the floating-point transfer and arithmetic unit.
// Function
// - Load address is base plus sign-extended 16-bit displacement.
// - Double load writes 64 bits; paired mode puts high word in target+1.
// - Word load with either low address bit set raises address error.
// - Narrow mode word load writes one half of an even register.
// - Wide mode word load fills low 32 bits of any register.
// - Word lane from address bit 2 with endian flips.
// - Float-to-integer move writes destination one cycle later.
// - In 64-bit mode that move sign-extends bit 31.
// - Narrow mode move reads one half of an even register.
// - Integer-to-float move completes one cycle later.
// - Wide mode integer-to-float move fills low 32 bits of any register.
// - Copy is non-arithmetic and raises no arithmetic exception.
// - Copy, multiply, negate accept only single and double formats.
// - Negate flips only the sign bit.
// - Negate of a NaN signals invalid operation.
// - Multiply rounds the exact product using the selected mode.
// - Round to long always uses round to nearest even.
// - Round to long of infinity, NaN or out of range is invalid.
// - With invalid trap off that conversion writes 2^63-1.
// - Multiply decoded by major opcode, format bit 4 and function code fields.
// - Register-width bit is bit 26 of the control register.
// - Double load with any of three low address bits set faults.
`ifndef FTU_DEFS_VH
`define FTU_DEFS_VH
`define FTU_F_OP 31:26
`define FTU_F_FMT 25:21
`define FTU_F_FT 20:16
`define FTU_F_FS 15:11
`define FTU_F_FD 10:6
`define FTU_F_FN 5:0
`define FTU_F_IMM 15:0
`define FTU_OP_COP 6'h11
`define FTU_OP_LOAD_WORD 6'h31
`define FTU_OP_LOAD_DOUBLE 6'h35
`define FTU_RS_MOVE_FROM 5'h00
`define FTU_RS_MOVE_TO 5'h04
`define FTU_FMT_S 5'h10
`define FTU_FMT_D 5'h11
`define FTU_FN_MUL 6'h02
`define FTU_FN_COPY 6'h06
`define FTU_FN_NEG 6'h07
`define FTU_FN_ROUND_L 6'h08
`define FTU_ADDR_CTRL 4'h0
`define FTU_ADDR_FLAGS 4'h4
`define FTU_CTRL_RESET 32'h00000000
`define FTU_CTRL_MASK 32'h04000B23
`define FTU_CTRL_RM 1:0
`define FTU_CTRL_MODE64 5
`define FTU_CTRL_BIG_END 8
`define FTU_CTRL_REV_END 9
`define FTU_CTRL_INV_EN 11
`define FTU_CTRL_WIDTH 26
`define FTU_FLAGS_RESET 6'h00
`define FTU_FL_INV 0
`define FTU_FL_INX 1
`define FTU_FL_OVF 2
`define FTU_FL_UNF 3
`define FTU_FL_UNIMP 4
`define FTU_FL_ADDR 5
`define FTU_BIAS_D 13'h03FF
`define FTU_BIAS_S 13'h007F
`define FTU_EMAX_D 13'h07FE
`define FTU_EMAX_S 13'h00FE
`define FTU_EXP_INF 11'h7FF
`define FTU_EXP_MAX 11'h7FE
`define FTU_FRAC_ONES 52'hFFFFFFFFFFFFF
`define FTU_NAN_D 64'h7FF7FFFFFFFFFFFF
`define FTU_NAN_S 64'h000000007FBFFFFF
`define FTU_LONG_MAX 64'h7FFFFFFFFFFFFFFF
`define FTU_LONG_MIN 64'h8000000000000000
`endif

//--- test/ftu_core_sva.sv
// Checker for decode, address and timing relations at the unit's ports.
`timescale 1ns/10ps
`default_nettype none
`include "ftu_defs.vh"
module ftu_core_sva (
    input wire logic mclk_i, // clock
    input wire logic rstn_i, // reset, low
    input wire logic issue_i, // issue
    input wire logic [31:0] instr_i, // instruction
    input wire logic [63:0] base_val_i, // load base
    input wire logic [3:0] reg_addr_i, // reg address
    input wire logic [31:0] reg_wdata_i, // reg data
    input wire logic reg_wr_i, // reg write
    input wire logic busy_o, // busy
    input wire logic mem_req_o, // mem request
    input wire logic [63:0] mem_addr_o, // mem address
    input wire logic mem_word_o, // word request
    input wire logic int_we_o, // int write
    input wire logic [4:0] int_dest_o, // int dest
    input wire logic [63:0] int_wdata_o, // int data
    input wire logic addr_err_o, // address error
    input wire logic unimpl_o, // unimplemented
    input wire logic fpe_o // trap
);
    logic [31:0] ctl_reg;
    logic take;
    logic is_lw;
    logic is_ld;
    logic is_mf;
    logic ar_op;
    logic [63:0] sum;
    logic [63:0] ea;
    ////////////////////////////////////////
    // Mode bits are shadowed since they shape load addresses.
    always @(posedge mclk_i) begin
        if (!rstn_i) begin
            ctl_reg <= 32'h0;
        end else if (reg_wr_i && reg_addr_i == `FTU_ADDR_CTRL) begin
            ctl_reg <= reg_wdata_i;
        end
    end
    assign take = issue_i && !busy_o;
    assign is_lw = take && instr_i[`FTU_F_OP] == `FTU_OP_LOAD_WORD;
    assign is_ld = take && instr_i[`FTU_F_OP] == `FTU_OP_LOAD_DOUBLE;
    assign is_mf = take && instr_i[31:21] == {`FTU_OP_COP, `FTU_RS_MOVE_FROM};
    assign ar_op = take && instr_i[`FTU_F_OP] == `FTU_OP_COP && instr_i[25]
        && instr_i[5:0] inside {6'h02, 6'h06, 6'h07, 6'h08};
    assign sum = base_val_i + {{48{instr_i[15]}}, instr_i[15:0]};
    assign ea = ctl_reg[`FTU_CTRL_MODE64] ? sum : {{32{sum[31]}}, sum[31:0]};
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rstn_i);
    ////////////////////////////////////////
    property p_mf_time; is_mf |=> int_we_o && int_dest_o == $past(instr_i[20:16]); endproperty
    a_mf_time: assert property (p_mf_time) else $error("late int write");
    property p_we_cause; int_we_o |-> $past(is_mf); endproperty
    a_we_cause: assert property (p_we_cause) else $error("stray int write");
    property p_mf_ext;
        int_we_o |-> int_wdata_o[63:32] == (ctl_reg[5] ? {32{int_wdata_o[31]}} : 32'h0);
    endproperty
    a_mf_ext: assert property (p_mf_ext) else $error("bad int upper half");
    property p_w_mis; is_lw && ea[1:0] != 2'h0 |=> addr_err_o && !mem_req_o; endproperty
    a_w_mis: assert property (p_w_mis) else $error("word misalign missed");
    property p_d_mis; is_ld && ea[2:0] != 3'h0 |=> addr_err_o && !mem_req_o; endproperty
    a_d_mis: assert property (p_d_mis) else $error("double misalign missed");
    property p_w_addr;
        is_lw && ea[1:0] == 2'h0 |=> mem_req_o && mem_word_o
            && mem_addr_o == {$past(ea[63:3]), $past(ea[2]) ^ ctl_reg[9], 2'h0};
    endproperty
    a_w_addr: assert property (p_w_addr) else $error("bad word address");
    property p_d_addr;
        is_ld && ea[2:0] == 3'h0 |=> mem_req_o && !mem_word_o && mem_addr_o == $past(ea);
    endproperty
    a_d_addr: assert property (p_d_addr) else $error("bad double address");
    property p_fmt; ar_op && instr_i[25:22] != 4'h8 |=> unimpl_o; endproperty
    a_fmt: assert property (p_fmt) else $error("bad format not flagged");
    property p_copy; ar_op && instr_i[`FTU_F_FN] == `FTU_FN_COPY |=> !fpe_o; endproperty
    a_copy: assert property (p_copy) else $error("copy trapped");
    property p_trap; fpe_o |-> ctl_reg[`FTU_CTRL_INV_EN]; endproperty
    a_trap: assert property (p_trap) else $error("trap while disabled");
    c_load: cover property (is_lw ##1 busy_o ##[1:20] !busy_o);
    c_move: cover property (is_mf ##1 int_we_o);
    c_trap: cover property (fpe_o);
endmodule
`default_nettype wire

//--- test/ftu_mem_model.sv
// Memory side model: answers each read request after a chosen delay.
`timescale 1ns/10ps
`default_nettype none
module ftu_mem_model (
    input wire logic mclk_i,        // core clock
    input wire logic rstn_i,        // reset, active low
    input wire logic mem_req_o,     // request from the unit
    input wire logic [63:0] data_i, // doubleword to return
    input wire logic [3:0] delay_i, // extra wait cycles
    output logic mem_valid_o,       // data valid pulse
    output logic [63:0] mem_data_o  // returned doubleword
);
    logic [4:0] cnt_reg = 5'h00;
    logic vld_reg = 1'h0;
    logic [63:0] dat_reg = 64'h0;
    assign mem_valid_o = vld_reg;
    assign mem_data_o = dat_reg;
    // Data toggles outside the valid cycle so sampling one cycle late never matches.
    always @(posedge mclk_i) begin
        vld_reg <= 1'h0;
        dat_reg <= ~dat_reg;
        if (!rstn_i) begin
            cnt_reg <= 5'h00;
        end else if (mem_req_o) begin
            cnt_reg <= {1'h0, delay_i} + 5'h01;
        end else if (cnt_reg != 5'h00) begin
            cnt_reg <= cnt_reg - 5'h01;
        end
        if (cnt_reg == 5'h01) begin
            vld_reg <= 1'h1;
            dat_reg <= data_i;
        end
    end
endmodule
`default_nettype wire

//--- test/tb_top.sv
// Self-checking testbench for the floating-point transfer unit.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic mclk_i = 0;
    logic rstn_i = 0;
    logic issue_i = 0, reg_wr_i = 0, reg_rd_i = 0;
    logic [31:0] instr_i = 0;
    logic [63:0] base_val_i = 0;
    logic [63:0] int_val_i = 0;
    logic [3:0] reg_addr_i = 0;
    logic [31:0] reg_wdata_i = 0;
    logic [63:0] mem_data_i, mem_addr_o, int_wdata_o;
    logic [31:0] reg_rdata_o;
    logic [4:0] int_dest_o;
    logic mem_valid_i, busy_o, mem_req_o, mem_word_o, int_we_o, addr_err_o, unimpl_o, fpe_o;
    logic [63:0] pd = 0;
    logic [3:0] pdl = 0;
    logic rd_d = 0;
    logic m64 = 0;
    int mismatches = 0, n_compared = 0;
    logic [68:0] q_int[$];
    logic [31:0] q_rd[$];
    always #10 mclk_i = ~mclk_i;
    ftu_core u_dut (.*);
    ftu_mem_model u_mem (.mclk_i, .rstn_i, .mem_req_o, .data_i(pd), .delay_i(pdl),
        .mem_valid_o(mem_valid_i), .mem_data_o(mem_data_i));
    ////////////////////////////////////////
    task automatic chk(string nm, logic [68:0] s, logic [68:0] e);
        n_compared++;
        if (s !== e) begin
            mismatches++;
            $display("[FAIL] %s exp %h seen %h", nm, e, s);
        end
    endtask
    task automatic wrap_up;
        mismatches += q_int.size() + q_rd.size();
        if (mismatches == 0 && n_compared > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic bus(logic w, logic [3:0] a, logic [31:0] d);
        @(posedge mclk_i);
        reg_wr_i <= w;
        reg_rd_i <= !w;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        if (!w) q_rd.push_back(d);
        @(posedge mclk_i);
        reg_wr_i <= 0;
        reg_rd_i <= 0;
    endtask
    task automatic sc(logic [31:0] c);
        bus(1, 4'h0, c);
        m64 = c[5];
    endtask
    task automatic iss(logic [31:0] i, logic [63:0] v);
        @(posedge mclk_i);
        issue_i <= 1;
        instr_i <= i;
        int_val_i <= v;
        base_val_i <= v;
    endtask
    task automatic gap;
        @(posedge mclk_i);
        issue_i <= 0;
    endtask
    task automatic mtc(logic [4:0] f, logic [31:0] v);
        iss({11'h224, 5'h0, f, 11'h0}, {$urandom, v});
    endtask
    task automatic mfc(logic [4:0] f, logic [31:0] e);
        iss({11'h220, ~f, f, 11'h0}, 0);
        q_int.push_back({~f, m64 ? {{32{e[31]}}, e} : {32'h0, e}});
    endtask
    task automatic ar(logic [5:0] fn, logic [4:0] fm, logic [4:0] fs, logic [4:0] fd);
        iss({6'h11, fm, fs, fs, fd, fn}, 0);
        gap;
    endtask
    task automatic ld(logic [5:0] op, logic [4:0] ft, logic [15:0] im, logic [63:0] b,
        logic [63:0] d);
        int k;
        pd <= d;
        pdl <= 4'($urandom_range(0, 6));
        iss({op, 5'h0, ft, im}, b);
        gap;
        k = 0;
        do begin
            @(posedge mclk_i);
            #1;
            k++;
        end while (busy_o !== 1'b0 && k < 30);
        if (k == 30) chk("load_done", 1, 0);
    endtask
    ////////////////////////////////////////
    always @(posedge mclk_i) begin
        rd_d <= reg_rd_i;
        if (rd_d) chk("reg_rdata", reg_rdata_o, q_rd.pop_front());
        if (int_we_o === 1'b1) chk("int_write", {int_dest_o, int_wdata_o}, q_int.pop_front());
    end
    initial begin
        #400000;
        mismatches++;
        wrap_up;
    end
    initial begin
        logic [31:0] a, b, x, y;
        logic [63:0] d, bs, ea;
        logic [15:0] im;
        logic [31:0] bad[3];
        void'($urandom(32'hB14672B2));
        repeat (8) @(posedge mclk_i);
        rstn_i <= 1;
        bus(0, 4'h0, 32'h0);
        bus(0, 4'h4, 32'h0);
        bus(0, 4'h8, 32'h0);
        sc(32'hFFFFFFFF);
        bus(0, 4'h0, 32'h04000B23);
        sc(32'h20);
        a = $urandom;
        b = $urandom;
        x = $urandom;
        y = $urandom;
        mtc(2, a);
        mtc(3, b);
        mtc(4, y);
        mtc(4, x);
        mfc(4, y);
        mfc(2, a);
        mfc(3, b);
        mfc(4, x);
        gap;
        sc(32'h04000020);
        mtc(5, a);
        gap;
        mfc(5, a);
        gap;
        sc(32'h04000000);
        mfc(5, a);
        gap;
        for (int e = 0; e < 4; e++) begin
            sc(32'h04000020 | (e << 8));
            d = {$urandom, $urandom};
            bs = {$urandom, $urandom} & ~64'h3;
            im = 16'($urandom) & 16'hFFFC;
            ea = bs + {{48{im[15]}}, im};
            ld(6'h31, 5'(16 + e), im, bs, d);
            mfc(5'(16 + e), (ea[2] ^ e[0]) ? d[63:32] : d[31:0]);
            gap;
        end
        sc(32'h20);
        ld(6'h31, 9, 16'h0, 64'h100, d);
        mfc(9, d[31:0]);
        ld(6'h35, 6, 16'h8, 64'h100, d);
        mfc(6, d[31:0]);
        mfc(7, d[63:32]);
        gap;
        d = ~d;
        sc(32'h04000020);
        ld(6'h35, 10, 16'hFFF8, 64'h208, d);
        sc(32'h20);
        mfc(10, d[31:0]);
        mfc(11, d[63:32]);
        gap;
        ld(6'h31, 1, 16'h2, 64'h100, d);
        ld(6'h35, 1, 16'h4, 64'h100, d);
        bus(0, 4'h4, 32'h20);
        // Arithmetic runs in wide mode, so odd register numbers are legal.
        sc(32'h04000020);
        mtc(10, 32'h3F800001);
        gap;
        for (int r = 0; r < 4; r++) begin
            sc(32'h04000020 | r);
            ar(6'h02, 5'h10, 10, 12);
            mfc(12, (r == 2) ? 32'h3F800003 : 32'h3F800002);
            gap;
        end
        ar(6'h07, 5'h10, 12, 13);
        ar(6'h06, 5'h10, 13, 14);
        mfc(13, 32'hBF800002);
        mfc(14, 32'hBF800002);
        gap;
        bus(1, 4'h4, 32'h3F);
        ar(6'h02, 5'h14, 10, 20);
        ar(6'h06, 5'h14, 10, 20);
        ar(6'h07, 5'h14, 10, 20);
        bus(0, 4'h4, 32'h10);
        bus(1, 4'h4, 32'h3F);
        mtc(15, 32'h7FC00000);
        gap;
        ar(6'h06, 5'h10, 15, 16);
        bus(0, 4'h4, 32'h0);
        ar(6'h07, 5'h10, 15, 17);
        mfc(17, 32'hFFC00000);
        gap;
        bus(0, 4'h4, 32'h1);
        sc(32'h04000022);
        mtc(18, 32'h40200000);
        mtc(19, 32'h40600000);
        gap;
        ar(6'h08, 5'h10, 18, 20);
        ar(6'h08, 5'h10, 19, 21);
        mfc(20, 32'h2);
        mfc(21, 32'h4);
        gap;
        bad = '{32'h7FC00000, 32'h7F800000, 32'h5F000000};
        foreach (bad[i]) begin
            bus(1, 4'h4, 32'h3F);
            mtc(22, bad[i]);
            gap;
            ar(6'h08, 5'h10, 22, 23);
            mfc(23, 32'hFFFFFFFF);
            gap;
            bus(0, 4'h4, 32'h1);
        end
        sc(32'h04000822);
        mtc(24, 32'h12345678);
        gap;
        ar(6'h08, 5'h10, 15, 24);
        mfc(24, 32'h12345678);
        gap;
        repeat (4) @(posedge mclk_i);
        wrap_up;
    end
endmodule
bind ftu_core ftu_core_sva u_sva (.*);
`default_nettype wire
